//--- shared/irq_enable_pkg.sv
// Package: constants for the interrupt enable mask register block
package irq_enable_pkg;
  localparam logic [7:0] MASK_ADDR = 8'hA8;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int GLOBAL_BIT = 7;
  localparam int SPI_BIT = 6;
  localparam int TIMER2_BIT = 5;
  localparam int UART_BIT = 4;
  localparam int TIMER1_BIT = 3;
  localparam int PIN1_BIT = 2;
  localparam int TIMER0_BIT = 1;
  localparam int PIN0_BIT = 0;
  localparam int NUM_SOURCES = 7;
endpackage

//--- hw/sfr_bit_merge.sv
// Bit-addressable write merge for one 8-bit special-function register
`timescale 1ns/1ps
module sfr_bit_merge (
  input wire logic [7:0] cur_i,
  input wire logic byte_wr_i,
  input wire logic [7:0] byte_data_i,
  input wire logic bit_wr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic bit_data_i,
  output logic [7:0] next_o
);
  logic [7:0] bit_mask;
  logic [7:0] bit_val;
  assign bit_mask = 8'h01 << bit_sel_i;
  assign bit_val = bit_data_i ? (cur_i | bit_mask) : (cur_i & ~bit_mask);
  // Byte write takes precedence if both arrive together
  assign next_o = byte_wr_i ? byte_data_i : (bit_wr_i ? bit_val : cur_i);
endmodule

//--- hw/irq_enable_mask.sv
// Interrupt enable mask register with per-source and global request gating
`timescale 1ns/1ps
module irq_enable_mask (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic bit_wr_i,
  input wire logic [7:0] bit_addr_i,
  input wire logic bit_wdata_i,
  input wire logic spi_irq_i,
  input wire logic uart_irq_i,
  input wire logic timer2_low_overflow_flag_i,
  input wire logic timer2_high_overflow_flag_i,
  input wire logic timer1_overflow_flag_i,
  input wire logic timer0_overflow_flag_i,
  input wire logic ext_irq_pin1_i,
  input wire logic ext_irq_pin0_i,
  output logic [6:0] irq_req_o,
  output logic [7:0] interrupt_enable_mask_o
);
  logic rst_meta_n;
  logic rst_n;
  logic [7:0] interrupt_enable_mask;
  logic [7:0] next_interrupt_enable_mask;
  logic [7:0] rdata;
  logic [6:0] src_pending;
  logic [6:0] src_enabled;
  logic [6:0] gated_req;
  // Byte address decode shared by the write and read paths
  function automatic logic sfr_addr_hit(input logic [7:0] addr);
    sfr_addr_hit = (addr == irq_enable_pkg::MASK_ADDR);
  endfunction

  // One-hot select of a bit within the register
  function automatic logic [7:0] bit_onehot(input logic [2:0] sel);
    bit_onehot = 8'h01 << sel;
  endfunction

  wire global_irq_enable = interrupt_enable_mask[irq_enable_pkg::GLOBAL_BIT];
  wire byte_hit = sfr_wr_i && sfr_addr_hit(sfr_addr_i);
  // Bit addresses of this register are 0xA8..0xAF
  wire bit_hit = bit_wr_i && (bit_addr_i[7:3] == irq_enable_pkg::MASK_ADDR[7:3]);
  wire rd_hit = sfr_rd_i && sfr_addr_hit(sfr_addr_i);
  // Checks stay off until both reset copies are high, so power-up unknowns never fire them
  wire chk_off = !rst_n_i || !rst_n;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  sfr_bit_merge u_merge (
    .cur_i(interrupt_enable_mask),
    .byte_wr_i(byte_hit),
    .byte_data_i(sfr_wdata_i),
    .bit_wr_i(bit_hit),
    .bit_sel_i(bit_addr_i[2:0]),
    .bit_data_i(bit_wdata_i),
    .next_o(next_interrupt_enable_mask)
  );

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_enable_mask <= irq_enable_pkg::MASK_RESET;
    end else begin
      interrupt_enable_mask <= next_interrupt_enable_mask;
    end
  end

  // Source order follows the per-source bit positions 0..6
  assign src_pending[irq_enable_pkg::PIN0_BIT] = ext_irq_pin0_i;
  assign src_pending[irq_enable_pkg::TIMER0_BIT] = timer0_overflow_flag_i;
  assign src_pending[irq_enable_pkg::PIN1_BIT] = ext_irq_pin1_i;
  assign src_pending[irq_enable_pkg::TIMER1_BIT] = timer1_overflow_flag_i;
  assign src_pending[irq_enable_pkg::UART_BIT] = uart_irq_i;
  assign src_pending[irq_enable_pkg::TIMER2_BIT] =
    timer2_low_overflow_flag_i | timer2_high_overflow_flag_i;
  assign src_pending[irq_enable_pkg::SPI_BIT] = spi_irq_i;
  assign src_enabled = interrupt_enable_mask[6:0];
  // Masking never touches the sources' flags, so held requests fire on re-enable
  assign gated_req = {7{global_irq_enable}} & src_enabled & src_pending;
  assign irq_req_o = gated_req;
  assign interrupt_enable_mask_o = interrupt_enable_mask;

  assign rdata = rd_hit ? interrupt_enable_mask : 8'h00;
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_o <= 8'h00;
    end else begin
      sfr_rdata_o <= rdata;
    end
  end

  // Register access checks
  reset_clear_a: assert property (@(posedge clk_sys_i)
    $rose(rst_n) |-> interrupt_enable_mask == irq_enable_pkg::MASK_RESET)
    else $error("mask not cleared by reset");

  reset_hold_a: assert property (@(posedge clk_sys_i)
    !rst_n |-> interrupt_enable_mask == irq_enable_pkg::MASK_RESET &&
      sfr_rdata_o == 8'h00 && irq_req_o == 7'h00)
    else $error("outputs not idle in reset");

  sync_release_a: assert property (@(posedge clk_sys_i)
    $rose(rst_n_i) |-> !rst_n ##1 !rst_n ##1 rst_n)
    else $error("reset release not delayed by two edges");

  byte_write_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    byte_hit |=> interrupt_enable_mask == $past(sfr_wdata_i))
    else $error("byte write not stored");

  byte_first_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    (byte_hit && bit_hit) |=> interrupt_enable_mask == $past(sfr_wdata_i))
    else $error("byte write did not win over bit write");

  bit_write_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    (bit_hit && !byte_hit) |=> interrupt_enable_mask[$past(bit_addr_i[2:0])] ==
      $past(bit_wdata_i))
    else $error("bit write not stored");

  bit_keep_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    (bit_hit && !byte_hit) |=>
      (interrupt_enable_mask & ~bit_onehot($past(bit_addr_i[2:0]))) ==
      ($past(interrupt_enable_mask) & ~bit_onehot($past(bit_addr_i[2:0]))))
    else $error("bit write disturbed other bits");

  idle_hold_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    (!byte_hit && !bit_hit) |=> interrupt_enable_mask == $past(interrupt_enable_mask))
    else $error("mask changed without a write");

  unmapped_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    (sfr_wr_i && !byte_hit && !bit_hit) |=> $stable(interrupt_enable_mask))
    else $error("write to another address changed the mask");

  bit_miss_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    (bit_wr_i && !bit_hit && !byte_hit) |=> $stable(interrupt_enable_mask))
    else $error("bit write outside the register changed the mask");

  read_data_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    rd_hit |=> sfr_rdata_o == $past(interrupt_enable_mask))
    else $error("read data wrong");

  read_other_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    !rd_hit |=> sfr_rdata_o == 8'h00)
    else $error("read data not zero when idle");

  // Request gating checks
  timer2_gate_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    irq_req_o[irq_enable_pkg::TIMER2_BIT] == (global_irq_enable &&
      interrupt_enable_mask[irq_enable_pkg::TIMER2_BIT] &&
      (timer2_low_overflow_flag_i || timer2_high_overflow_flag_i)))
    else $error("timer 2 request gating wrong");

  timer1_gate_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    irq_req_o[irq_enable_pkg::TIMER1_BIT] == (global_irq_enable &&
      interrupt_enable_mask[irq_enable_pkg::TIMER1_BIT] && timer1_overflow_flag_i))
    else $error("timer 1 request gating wrong");

  timer0_gate_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    irq_req_o[irq_enable_pkg::TIMER0_BIT] == (global_irq_enable &&
      interrupt_enable_mask[irq_enable_pkg::TIMER0_BIT] && timer0_overflow_flag_i))
    else $error("timer 0 request gating wrong");

  global_off_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    !global_irq_enable |-> irq_req_o == 7'h00)
    else $error("request passed with global enable off");

  held_request_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    (!global_irq_enable && interrupt_enable_mask[irq_enable_pkg::UART_BIT] && uart_irq_i) ##1
      (global_irq_enable && interrupt_enable_mask[irq_enable_pkg::UART_BIT] && uart_irq_i)
      |-> irq_req_o[irq_enable_pkg::UART_BIT])
    else $error("held request not served after re-enable");

  pin_gate_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    irq_req_o[irq_enable_pkg::PIN0_BIT] == (global_irq_enable &&
      interrupt_enable_mask[irq_enable_pkg::PIN0_BIT] && ext_irq_pin0_i))
    else $error("pin 0 request gating wrong");

  pin1_gate_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    irq_req_o[irq_enable_pkg::PIN1_BIT] == (global_irq_enable &&
      interrupt_enable_mask[irq_enable_pkg::PIN1_BIT] && ext_irq_pin1_i))
    else $error("pin 1 request gating wrong");

  uart_gate_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    irq_req_o[irq_enable_pkg::UART_BIT] == (global_irq_enable &&
      interrupt_enable_mask[irq_enable_pkg::UART_BIT] && uart_irq_i))
    else $error("uart request gating wrong");

  spi_gate_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    irq_req_o[irq_enable_pkg::SPI_BIT] == (global_irq_enable &&
      interrupt_enable_mask[irq_enable_pkg::SPI_BIT] && spi_irq_i))
    else $error("serial peripheral request gating wrong");

  no_spurious_a: assert property (@(posedge clk_sys_i) disable iff (chk_off)
    (irq_req_o & ~src_enabled) == 7'h00)
    else $error("request passed for a masked source");

  // Main scenarios
  enable_cov: cover property (@(posedge clk_sys_i) disable iff (chk_off)
    byte_hit ##1 global_irq_enable);
  req_cov: cover property (@(posedge clk_sys_i) disable iff (chk_off)
    irq_req_o[irq_enable_pkg::TIMER2_BIT]);
  reenable_cov: cover property (@(posedge clk_sys_i) disable iff (chk_off)
    !global_irq_enable && |src_pending ##1 |irq_req_o);
  byte_bit_cov: cover property (@(posedge clk_sys_i) disable iff (chk_off)
    byte_hit && bit_hit);
  read_cov: cover property (@(posedge clk_sys_i) disable iff (chk_off)
    rd_hit ##1 sfr_rdata_o != 8'h00);
endmodule

//--- verif/irq_source_model.sv
// Model of the peripheral pending flags feeding the enable mask block
`timescale 1ns/1ps
module irq_source_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] set_i,
  output logic [7:0] flag_o
);
  // Flags are held levels registered from set_i; only set_i dropping or reset clears them
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_o <= 8'h00;
    end else begin
      flag_o <= set_i;
    end
  end
endmodule

//--- verif/tb_irq_enable_mask.sv
// Self-checking bench for the interrupt enable mask register
`timescale 1ns/1ps
module tb_irq_enable_mask;
  localparam logic [7:0] A = irq_enable_pkg::MASK_ADDR;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, bwr = 0, bdat = 0;
  logic [7:0] addr = 0, wdat = 0, baddr = 0, set = 0, rdata, mask, flag;
  logic [6:0] req;
  int num_errors = 0, checked = 0;
  irq_source_model irq_source_model_inst (.clk_sys_i(clk), .rst_n_i(rst_n), .set_i(set),
    .flag_o(flag));
  irq_enable_mask irq_enable_mask_inst (.clk_sys_i(clk), .rst_n_i(rst_n), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_wdata_i(wdat), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .bit_wr_i(bwr),
    .bit_addr_i(baddr), .bit_wdata_i(bdat), .spi_irq_i(flag[6]), .uart_irq_i(flag[4]),
    .timer2_low_overflow_flag_i(flag[5]), .timer2_high_overflow_flag_i(flag[7]),
    .timer1_overflow_flag_i(flag[3]), .timer0_overflow_flag_i(flag[1]),
    .ext_irq_pin1_i(flag[2]), .ext_irq_pin0_i(flag[0]), .irq_req_o(req),
    .interrupt_enable_mask_o(mask));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    {addr, wdat, wr} = {a, d, 1'b1};
    @(posedge clk) #1;
    wr = 0;
  endtask
  task automatic bit1(input logic [7:0] a, input logic v);
    @(posedge clk) #1;
    {baddr, bdat, bwr} = {a, v, 1'b1};
    @(posedge clk) #1;
    bwr = 0;
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) #1;
    {addr, rd} = {a, 1'b1};
    @(posedge clk) #1;
    rd = 0;
    chk(rdata, exp);
  endtask
  // Flags land through the model's register, so requests are seen one edge later
  task automatic src(input logic [7:0] f, input logic [7:0] exp);
    set = f;
    @(posedge clk) #1;
    chk({1'b0, req}, exp);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    end_of_test;
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1;
    repeat (3) @(posedge clk);
    rd8(A, 8'h00);
    src(8'hFF, 8'h00);
    $display("test reset done");
    for (int n = 0; n < 7; n++) begin
      wr8(A, 8'h80 | (8'h01 << n));
      src(8'hFF, 8'h01 << n);
      src(~(8'h01 << n) & 8'h7F, 8'h00);
    end
    wr8(A, 8'hA0);
    src(8'h20, 8'h20);
    src(8'h80, 8'h20);
    $display("test per source done");
    wr8(A, 8'h7F);
    src(8'hFF, 8'h00);
    bit1(8'hAF, 1'b1);
    chk({1'b0, req}, 8'h7F);
    rd8(A, 8'hFF);
    $display("test global done");
    bit1(8'hA8, 1'b0);
    chk(mask, 8'hFE);
    wr8(8'hA9, 8'h00);
    bit1(8'hB0, 1'b0);
    rd8(8'hA9, 8'h00);
    rd8(A, 8'hFE);
    $display("test bit and unmapped done");
    // Byte and bit write in one cycle: the byte write wins
    @(posedge clk) #1;
    {addr, wdat, wr, baddr, bdat, bwr} = {A, 8'h0F, 1'b1, 8'hAF, 1'b1, 1'b1};
    @(posedge clk) #1;
    {wr, bwr} = 2'b00;
    chk(mask, 8'h0F);
    rst_n = 0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    chk(mask, 8'h00);
    repeat (3) @(posedge clk);
    rd8(A, 8'h00);
    src(8'hFF, 8'h00);
    $display("test byte priority and mid-run reset done");
    end_of_test;
  end
endmodule
